//--- dfx_cmd_exec.sv
/*
  Command executor for block fill writes, resume, resume-until-halt, null
  and CPU register read. Assumes the framing layer offers one command at a
  time while this block is idle, and that memory, CPU and status inputs
  are on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dfx_cmd_exec
  import dfx_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic sync_in,
  input wire logic ack_en_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic other_cmd_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  output logic ack_pulse_out,
  output logic illegal_cmd_out,
  output logic timeout_hold_out,
  input wire logic wrmem_done_in,
  input wire logic [ADDR_W-1:0] wrmem_addr_in,
  input wire logic [1:0] wrmem_sz_in,
  output logic mem_req_out,
  output dfx_mem_wr_t mem_wr_out,
  input wire logic mem_done_in,
  input wire logic mem_abort_in,
  input wire logic [7:0] low_status_byte_in,
  input wire logic active_debug_state_in,
  output logic resume_out,
  output logic reg_req_out,
  output logic [CRN_W-1:0] cpu_register_number_out,
  input wire logic reg_done_in,
  input wire logic [31:0] reg_data_in,
  input wire logic [3:0] reg_bytes_impl_in
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [2:0] sz_bytes(input logic [1:0] sz);
    unique case (sz)
      2'h0: sz_bytes = 3'h1;
      2'h1: sz_bytes = 3'h2;
      default: sz_bytes = 3'h4;
    endcase
  endfunction

  function automatic logic is_fill(input logic [7:0] c);
    is_fill = ((c & CMD_FILL_MASK) == CMD_FILL_BASE)
      && (c[CMD_SZ_LSB +: 2] != SZ_RESERVED);
  endfunction

  dfx_state_t st_reg;
  logic [ADDR_W-1:0] tmp_addr_reg;
  logic addr_valid_reg;
  logic chain_ok_reg;
  logic [1:0] sz_reg;
  logic ws_reg;
  logic until_reg;
  logic [2:0] cnt_reg;
  logic [31:0] data_reg;
  logic [CRN_W-1:0] crn_reg;
  logic tx_valid_reg;
  logic [7:0] tx_data_reg;
  logic ack_reg;
  logic illegal_reg;
  logic resume_reg;

  logic take;
  logic c_fill;
  logic c_go;
  logic c_until;
  logic c_null;
  logic c_rd;
  logic fill_bad;
  logic mem_end;
  logic tx_take;
  logic [2:0] fill_step;
  logic [31:0] reg_masked;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  assign take = cmd_valid_in && (st_reg == S_IDLE) && !sync_in;
  assign c_fill = take && is_fill(cmd_code_in); // [R1]
  assign c_go = take && (cmd_code_in == CMD_GO); // [R26]
  assign c_until = take && (cmd_code_in == CMD_GO_UNTIL); // [R26]
  assign c_null = take && (cmd_code_in == CMD_NULL); // [R26]
  assign c_rd = take && ((cmd_code_in & CMD_RDREG_MASK) == CMD_RDREG_BASE); // [R19]
  assign fill_bad = !addr_valid_reg || !chain_ok_reg; // [R2] [R7]
  assign mem_end = mem_done_in || mem_abort_in;
  assign tx_take = tx_valid_reg && tx_ready_in;
  assign fill_step = sz_bytes(sz_reg);

  // Missing bytes forced to zero so narrow registers still read as 32 bits
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mask
      assign reg_masked[gi*8 +: 8] = reg_bytes_impl_in[gi] ? reg_data_in[gi*8 +: 8] : 8'h00; // [R20]
    end
  endgenerate

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || sync_in) begin
      st_reg <= S_IDLE; // [R25]
    end else begin
      unique case (st_reg)
        S_IDLE: begin
          if (c_fill && !fill_bad) begin
            st_reg <= S_RX;
          end else if ((c_go || c_until) && active_debug_state_in) begin
            st_reg <= S_GO_LEAVE; // [R10]
          end else if (c_rd && active_debug_state_in) begin
            st_reg <= S_RREQ;
          end
        end
        S_RX: begin
          if (rx_valid_in && cnt_reg == 3'h1) begin
            st_reg <= S_WR;
          end
        end
        S_WR: begin
          if (mem_end) begin
            st_reg <= ws_reg ? S_STAT : S_IDLE;
          end
        end
        S_STAT: begin
          if (tx_take) begin
            st_reg <= S_IDLE;
          end
        end
        S_RREQ: begin
          if (reg_done_in) begin
            st_reg <= S_RTX;
          end
        end
        S_RTX: begin
          if (tx_take && cnt_reg == 3'h1) begin
            st_reg <= S_IDLE;
          end
        end
        S_GO_LEAVE: begin
          if (!active_debug_state_in) begin
            st_reg <= until_reg ? S_GO_HALT : S_IDLE;
          end
        end
        S_GO_HALT: begin
          if (active_debug_state_in) begin
            st_reg <= S_IDLE; // [R13]
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Operand capture and byte counting
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sz_reg <= 2'h0;
      ws_reg <= 1'b0;
      until_reg <= 1'b0;
      cnt_reg <= 3'h0;
      data_reg <= 32'h0000_0000;
      crn_reg <= '0;
    end else if (c_fill) begin
      sz_reg <= cmd_code_in[CMD_SZ_LSB +: 2]; // [R9]
      ws_reg <= cmd_code_in[CMD_WS_BIT]; // [R5]
      cnt_reg <= sz_bytes(cmd_code_in[CMD_SZ_LSB +: 2]);
      data_reg <= 32'h0000_0000;
    end else if (c_go || c_until) begin
      until_reg <= c_until && ack_en_in; // [R17]
    end else if (c_rd) begin
      crn_reg <= cmd_code_in[CRN_W-1:0];
    end else if (st_reg == S_RX && rx_valid_in) begin
      data_reg <= {data_reg[23:0], rx_data_in}; // [R1]
      cnt_reg <= cnt_reg - 3'h1;
    end else if (st_reg == S_RREQ && reg_done_in) begin
      data_reg <= reg_masked; // [R20]
      cnt_reg <= REG_BYTES;
    end else if (st_reg == S_RTX && tx_take) begin
      data_reg <= {data_reg[23:0], 8'h00}; // [R19]
      cnt_reg <= cnt_reg - 3'h1;
    end
  end

  // ----------------------------------------
  // Fill pointer and legality tracking
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      tmp_addr_reg <= '0;
      addr_valid_reg <= 1'b0;
    end else if (wrmem_done_in) begin
      tmp_addr_reg <= wrmem_addr_in + ADDR_W'(sz_bytes(wrmem_sz_in)); // [R3]
      addr_valid_reg <= 1'b1;
    end else if (st_reg == S_WR && mem_end) begin
      tmp_addr_reg <= tmp_addr_reg + ADDR_W'(fill_step); // [R4]
    end
  end

  // Null keeps the chain; sync, addressed write and fill restore it; other commands break it
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || sync_in) begin
      chain_ok_reg <= 1'b1; // [R7]
    end else if (wrmem_done_in || c_fill) begin
      chain_ok_reg <= 1'b1;
    end else if (c_null) begin
      chain_ok_reg <= chain_ok_reg; // [R8] [R18]
    end else if (other_cmd_in || (take && !c_null)) begin
      chain_ok_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Return byte path
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || sync_in) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end else if (tx_take) begin
      tx_valid_reg <= 1'b0;
    end else if (st_reg == S_STAT && !tx_valid_reg) begin
      // Loaded a cycle after the write ends so status shows its result
      tx_valid_reg <= 1'b1;
      tx_data_reg <= low_status_byte_in; // [R5]
    end else if (st_reg == S_RTX && !tx_valid_reg && !ack_reg) begin
      tx_valid_reg <= 1'b1;
      tx_data_reg <= data_reg[31:24]; // [R21]
    end
  end

  // ----------------------------------------
  // Acknowledge, illegal and resume pulses
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || sync_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_en_in && (
        (st_reg == S_WR && mem_end) || // [R6]
        (st_reg == S_RREQ && reg_done_in) || // [R21]
        (st_reg == S_GO_LEAVE && !active_debug_state_in && !until_reg) || // [R11]
        (st_reg == S_GO_HALT && active_debug_state_in)); // [R13] [R23]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      illegal_reg <= 1'b0;
    end else begin
      illegal_reg <= (c_fill && fill_bad) || // [R2] [R7]
        ((c_go || c_until) && !active_debug_state_in) || // [R12] [R16]
        (c_rd && !active_debug_state_in); // [R22]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      resume_reg <= 1'b0;
    end else begin
      resume_reg <= (c_go || c_until) && active_debug_state_in; // [R10]
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign tx_valid_out = tx_valid_reg;
  assign tx_data_out = tx_data_reg;
  assign ack_pulse_out = ack_reg;
  assign illegal_cmd_out = illegal_reg;
  assign resume_out = resume_reg;
  // Host must sync if the halt never comes; this hold lasts until then
  assign timeout_hold_out = (st_reg == S_GO_HALT) ||
    (st_reg == S_GO_LEAVE && until_reg); // [R14] [R15]
  assign mem_req_out = (st_reg == S_WR);
  assign mem_wr_out = '{addr: tmp_addr_reg, data: data_reg, size: sz_reg}; // [R4]
  assign reg_req_out = (st_reg == S_RREQ); // [R22]
  assign cpu_register_number_out = crn_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_fill_no_addr: // [R2]
    assert property (@(posedge ref_clk_in) disable iff (srst_in)
      c_fill && !addr_valid_reg |=> illegal_cmd_out && st_reg == S_IDLE)
    else $error("fill without seed address not refused");

  a_fill_chain: // [R7]
    assert property (@(posedge ref_clk_in) disable iff (srst_in)
      c_fill && !chain_ok_reg |=> illegal_cmd_out && !mem_req_out)
    else $error("fill after breaking command not refused");

  a_fill_step: // [R4]
    assert property (@(posedge ref_clk_in) disable iff (srst_in || wrmem_done_in)
      st_reg == S_WR && mem_end |=>
        tmp_addr_reg == $past(tmp_addr_reg) + ADDR_W'(sz_bytes($past(sz_reg))))
    else $error("fill pointer did not advance by operand size");

  a_null_keeps: // [R8]
    assert property (@(posedge ref_clk_in) disable iff (srst_in)
      c_null && !wrmem_done_in |=> $stable(tmp_addr_reg) && st_reg == S_IDLE)
    else $error("null command disturbed state");

  a_fill_ack: // [R6]
    assert property (@(posedge ref_clk_in) disable iff (srst_in || sync_in)
      st_reg == S_WR && mem_end && ack_en_in |=> ack_pulse_out)
    else $error("fill acknowledge missing after write end");

  a_go_illegal: // [R12]
    assert property (@(posedge ref_clk_in) disable iff (srst_in)
      (c_go || c_until) && !active_debug_state_in |=> illegal_cmd_out && !resume_out)
    else $error("resume outside debug state not refused");

  a_rd_illegal: // [R22]
    assert property (@(posedge ref_clk_in) disable iff (srst_in)
      c_rd && !active_debug_state_in |=> illegal_cmd_out ##1 !reg_req_out)
    else $error("register read outside debug state accessed");

  a_until_hold: // [R14]
    assert property (@(posedge ref_clk_in) disable iff (srst_in || sync_in)
      c_until && ack_en_in && active_debug_state_in |=> timeout_hold_out)
    else $error("timeout not held for pending resume-until");

  a_rd_zero: // [R20]
    assert property (@(posedge ref_clk_in) disable iff (srst_in || sync_in)
      st_reg == S_RREQ && reg_done_in && !reg_bytes_impl_in[3] |=>
        data_reg[31:24] == 8'h00)
    else $error("unimplemented register byte not zero");

  a_resume_pulse: // [R10]
    assert property (@(posedge ref_clk_in) disable iff (srst_in)
      (c_go || c_until) && active_debug_state_in |=> resume_out && !illegal_cmd_out)
    else $error("resume pulse missing in debug state");

  a_go_ack: // [R11]
    assert property (@(posedge ref_clk_in) disable iff (srst_in || sync_in)
      st_reg == S_GO_LEAVE && !active_debug_state_in && !until_reg && ack_en_in |=>
        ack_pulse_out)
    else $error("resume acknowledge missing on leaving debug state");

  a_until_wait: // [R13]
    assert property (@(posedge ref_clk_in) disable iff (srst_in || sync_in)
      st_reg == S_GO_HALT && !active_debug_state_in |=> !ack_pulse_out && timeout_hold_out)
    else $error("resume-until acknowledged before halt");

  a_fill_status: // [R5]
    assert property (@(posedge ref_clk_in) disable iff (srst_in || sync_in)
      st_reg == S_STAT && !tx_valid_reg |=>
        tx_valid_out && tx_data_out == $past(low_status_byte_in))
    else $error("status byte not offered after fill write");

  a_rd_ack_first: // [R21]
    assert property (@(posedge ref_clk_in) disable iff (srst_in || sync_in)
      st_reg == S_RREQ && reg_done_in && ack_en_in |=> ack_pulse_out && !tx_valid_out)
    else $error("register data offered before acknowledge");

endmodule

`default_nettype wire

//--- dfx_pkg.sv
/*
  Constants, carrier types and state codes for the debug command executor
  that handles block fill, resume, null and CPU register read commands.
  Assumes the serial framing layer outside delivers whole command and data
  bytes on the executor clock and serialises the bytes it returns.
*/
// Behaviour
// [R1] Fill codes 0x13/0x17/0x1B, data MSB first
// [R2] Fill without prior addressed write is illegal
// [R3] Addressed write seeds pointer with address+size
// [R4] Fill writes at pointer, then advances it
// [R5] Status variant returns status after write
// [R6] Fill acknowledge only after write ends
// [R7] Fill legal only after sync/null/write/fill
// [R8] Null leaves the fill pointer untouched
// [R9] Size field decoded afresh every fill
// [R10] Resume leaves debug state, restarts CPU fetch
// [R11] Resume acknowledges on leaving debug state
// [R12] Resume outside debug state is illegal
// [R13] Resume-until acknowledges on re-entering debug
// [R14] No timeout while resume-until acknowledge pends
// [R15] Host syncs to end unacknowledged resume-until
// [R16] Resume-until outside debug state is illegal
// [R17] Without acknowledge, resume-until equals resume
// [R18] Null command changes nothing
// [R19] Register read 0x60+number returns 32 bits
// [R20] Unimplemented register bytes read as zero
// [R21] Register read acknowledges before data bytes
// [R22] Register read outside debug: illegal, no access
// [R23] Acknowledge pulse when handshake enabled
// [R24] Host waits 16 clocks per gap without ack
// [R25] Sync discards incomplete command
// [R26] Resume and null codes from command table
package dfx_pkg;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_FILL_BASE = 8'h12;
  localparam logic [7:0] CMD_FILL_MASK = 8'hF2;
  localparam int CMD_WS_BIT = 0;
  localparam int CMD_SZ_LSB = 2;
  localparam logic [1:0] SZ_RESERVED = 2'h3;
  localparam logic [7:0] CMD_GO = 8'h08;
  localparam logic [7:0] CMD_GO_UNTIL = 8'h0C;
  localparam logic [7:0] CMD_NULL = 8'h00;
  localparam logic [7:0] CMD_RDREG_BASE = 8'h60;
  localparam logic [7:0] CMD_RDREG_MASK = 8'hE0;

  // ----------------------------------------
  // Widths and counts
  // ----------------------------------------
  localparam int ADDR_W = 24;
  localparam int CRN_W = 5;
  localparam logic [2:0] REG_BYTES = 3'h4;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [1:0] size;
  } dfx_mem_wr_t;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_RX = 8'h02,
    S_WR = 8'h04,
    S_STAT = 8'h08,
    S_RREQ = 8'h10,
    S_RTX = 8'h20,
    S_GO_LEAVE = 8'h40,
    S_GO_HALT = 8'h80
  } dfx_state_t;

endpackage

//--- dfx_far_model.sv
/*
  Far-side model: memory write port, CPU register port and byte sink.
  Assumes requests are held until answered, all on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dfx_far_model
  import dfx_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic slow_in,
  input wire logic abort_in,
  input wire logic mem_req_in,
  output logic mem_done_out,
  output logic mem_abort_out,
  input wire logic reg_req_in,
  input wire logic [31:0] reg_value_in,
  input wire logic [3:0] reg_impl_in,
  output logic reg_done_out,
  output logic [31:0] reg_data_out,
  output logic [3:0] reg_bytes_impl_out,
  input wire logic tx_valid_in,
  output logic tx_ready_out
);
  logic [3:0] dly;
  logic [3:0] mcnt_reg, rcnt_reg, tcnt_reg;
  logic mhit;
  assign dly = slow_in ? 4'h6 : 4'h1;
  assign mhit = mem_req_in && (mcnt_reg == dly);
  assign mem_done_out = mhit && !abort_in;
  assign mem_abort_out = mhit && abort_in;
  assign reg_done_out = reg_req_in && (rcnt_reg == dly);
  // Idle lines show the inverse, so a stale value never matches
  assign reg_data_out = reg_done_out ? reg_value_in : ~reg_value_in;
  assign reg_bytes_impl_out = reg_done_out ? reg_impl_in : ~reg_impl_in;
  assign tx_ready_out = tx_valid_in && (tcnt_reg == dly);
  always_ff @(posedge ref_clk_in) begin
    mcnt_reg <= (srst_in || !mem_req_in || mhit) ? 4'h0 : mcnt_reg + 4'h1;
    rcnt_reg <= (srst_in || !reg_req_in || reg_done_out) ? 4'h0 : rcnt_reg + 4'h1;
    tcnt_reg <= (srst_in || !tx_valid_in || tx_ready_out) ? 4'h0 : tcnt_reg + 4'h1;
  end
endmodule
`default_nettype wire

//--- tb_dfx_cmd_exec.sv
/*
  Self-checking bench for the command executor with a far-side model.
  Assumes one clock, synchronous reset, whole bytes at the ports.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_dfx_cmd_exec
  import dfx_pkg::*;
;
  logic clk, rst, sync, ack_en, cmd_valid, other_cmd, rx_valid, wrmem_done, active;
  logic slow, abort, tx_valid, tx_ready, ack, ill, hold, mem_req, mem_done, mem_abort;
  logic resume, reg_req, reg_done;
  logic [7:0] cmd_code, rx_data, status, tx_data;
  logic [ADDR_W-1:0] wr_addr;
  logic [1:0] wr_sz;
  logic [31:0] reg_val, reg_data, seed;
  logic [3:0] reg_impl, reg_bi;
  logic [CRN_W-1:0] cpu_register_number;
  dfx_mem_wr_t mem_wr;
  dfx_mem_wr_t wrq[$];
  logic [7:0] txq[$];
  int error_cnt, samples_checked, ack_c, ill_c, res_c, bad_c, hold_c, first_ack, ptr, n, a;
  logic [7:0] fcodes [6] = '{8'h13, 8'h17, 8'h1B, 8'h12, 8'h16, 8'h1A};
  dfx_cmd_exec dfx_cmd_exec_inst (.ref_clk_in(clk), .srst_in(rst), .sync_in(sync),
    .ack_en_in(ack_en), .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code),
    .other_cmd_in(other_cmd), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_ready_in(tx_ready),
    .ack_pulse_out(ack), .illegal_cmd_out(ill), .timeout_hold_out(hold),
    .wrmem_done_in(wrmem_done), .wrmem_addr_in(wr_addr), .wrmem_sz_in(wr_sz),
    .mem_req_out(mem_req), .mem_wr_out(mem_wr), .mem_done_in(mem_done),
    .mem_abort_in(mem_abort), .low_status_byte_in(status),
    .active_debug_state_in(active), .resume_out(resume), .reg_req_out(reg_req),
    .cpu_register_number_out(cpu_register_number), .reg_done_in(reg_done), .reg_data_in(reg_data),
    .reg_bytes_impl_in(reg_bi));
  dfx_far_model dfx_far_model_inst (.ref_clk_in(clk), .srst_in(rst), .slow_in(slow),
    .abort_in(abort), .mem_req_in(mem_req), .mem_done_out(mem_done),
    .mem_abort_out(mem_abort), .reg_req_in(reg_req), .reg_value_in(reg_val),
    .reg_impl_in(reg_impl), .reg_done_out(reg_done), .reg_data_out(reg_data),
    .reg_bytes_impl_out(reg_bi), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready));
  // ----------------------------------------
  // Clock and monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Sampled on the falling edge so the bench never races the design
  always @(negedge clk) begin
    if (!rst) begin
      if (ack) ack_c++;
      if (ill) ill_c++;
      if (resume) res_c++;
      if (hold) hold_c++;
      if (ack && mem_req) bad_c++;
      if (tx_valid && mem_req) bad_c++;
      if (mem_req && (mem_done || mem_abort)) wrq.push_back(mem_wr);
      if (tx_valid && tx_ready) begin
        if (txq.size() == 0) first_ack = ack_c;
        txq.push_back(tx_data);
      end
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_wr(input dfx_mem_wr_t e, input dfx_mem_wr_t g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] fill write exp %h got %h", e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wait_cnt(input int w, input int t);
    for (int i = 0; i < 300; i++) begin
      if ((w == 0 ? ack_c : w == 1 ? wrq.size() : txq.size()) >= t) return;
      tick(1);
    end
    error_cnt++;
    $display("[ERR] wait %0d exp %0d got none", w, t);
    print_verdict();
  endtask
  task automatic send_cmd(input logic [7:0] c);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    tick(1);
    cmd_valid <= 1'b0;
    tick(1);
  endtask
  task automatic send_byte(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_data <= b;
    tick(1);
    rx_valid <= 1'b0;
    tick(1);
  endtask
  task automatic expect_ill(input logic [7:0] c);
    int k;
    k = ill_c;
    send_cmd(c);
    tick(2);
    chk_val("illegal", k + 1, ill_c);
  endtask
  task automatic seed_ptr(input logic [ADDR_W-1:0] ad, input logic [1:0] sz);
    wrmem_done <= 1'b1;
    wr_addr <= ad;
    wr_sz <= sz;
    tick(1);
    wrmem_done <= 1'b0;
    tick(1);
    ptr = int'(ad) + (1 << sz);
  endtask
  task automatic fill(input logic [7:0] c, input logic [31:0] d);
    dfx_mem_wr_t e;
    int nb, k;
    nb = 1 << c[3:2];
    k = ack_c;
    wrq.delete();
    txq.delete();
    send_cmd(c);
    for (int i = nb - 1; i >= 0; i--) send_byte(d[8*i+:8]);
    wait_cnt(1, 1);
    e.addr = ADDR_W'(ptr);
    e.data = (nb == 4) ? d : d & ((32'h1 << (8 * nb)) - 32'h1);
    e.size = c[3:2];
    chk_wr(e, wrq[0]);
    ptr += nb;
    wait_cnt(0, k + 1);
    chk_val("fill ack", k + 1, ack_c);
    if (c[0]) begin
      wait_cnt(2, 1);
      chk_val("status", status, txq[0]);
    end
    tick(2);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hFC203121;
    {rst, sync, ack_en, cmd_valid, other_cmd, rx_valid, wrmem_done, active} = 8'h80;
    {slow, abort, cmd_code, rx_data, status, wr_addr, wr_sz} = '0;
    reg_val = 32'h0;
    reg_impl = 4'h0;
    tick(20);
    rst <= 1'b0;
    ack_en <= 1'b1;
    tick(2);
    expect_ill(8'h17);
    seed_ptr(ADDR_W'(xs()) & 24'hFFFFFC, 2'h2);
    n = ill_c;
    for (int k = 0; k < 6; k++) begin
      slow <= k[0];
      status <= 8'(xs());
      if (k == 2) send_cmd(CMD_NULL);
      fill(fcodes[k], xs());
    end
    chk_val("no illegal", n, ill_c);
    abort <= 1'b1;
    fill(8'h1B, xs());
    abort <= 1'b0;
    other_cmd <= 1'b1;
    tick(1);
    other_cmd <= 1'b0;
    tick(1);
    expect_ill(8'h13);
    seed_ptr(ADDR_W'(xs()), 2'h0);
    other_cmd <= 1'b1;
    tick(1);
    other_cmd <= 1'b0;
    sync <= 1'b1;
    tick(1);
    sync <= 1'b0;
    tick(1);
    fill(8'h12, xs());
    n = txq.size();
    expect_ill(CMD_GO);
    expect_ill(CMD_GO_UNTIL);
    expect_ill(8'h6B);
    chk_val("no reg access", n, txq.size());
    active <= 1'b1;
    tick(2);
    n = res_c;
    a = ack_c;
    send_cmd(CMD_GO);
    chk_val("resume", n + 1, res_c);
    tick(3);
    chk_val("go early ack", a, ack_c);
    active <= 1'b0;
    wait_cnt(0, a + 1);
    chk_val("go ack", a + 1, ack_c);
    active <= 1'b1;
    tick(2);
    a = ack_c;
    n = hold_c;
    send_cmd(CMD_GO_UNTIL);
    active <= 1'b0;
    tick(10);
    chk_val("until hold", 1, hold_c - n >= 8);
    chk_val("until early ack", a, ack_c);
    active <= 1'b1;
    wait_cnt(0, a + 1);
    chk_val("until ack", a + 1, ack_c);
    tick(2);
    send_cmd(CMD_GO_UNTIL);
    active <= 1'b0;
    tick(5);
    sync <= 1'b1;
    tick(1);
    sync <= 1'b0;
    tick(2);
    n = hold_c;
    active <= 1'b1;
    tick(4);
    chk_val("sync hold", n, hold_c);
    chk_val("sync ack", a + 1, ack_c);
    ack_en <= 1'b0;
    n = hold_c;
    a = res_c;
    send_cmd(CMD_GO_UNTIL);
    active <= 1'b0;
    tick(4);
    chk_val("plain until", a + 1, res_c);
    chk_val("plain hold", n, hold_c);
    active <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      ack_en <= (k < 3);
      slow <= k[0];
      reg_val <= xs();
      reg_impl <= (k == 0) ? 4'hF : 4'(xs());
      n = 8'(xs()) % 32;
      a = ack_c;
      txq.delete();
      tick(1);
      send_cmd(CMD_RDREG_BASE + 8'(n));
      // Without handshake the host sits out the fixed delay gap
      if (k == 3) tick(16);
      wait_cnt(2, 4);
      chk_val("reg number", n, cpu_register_number);
      for (int i = 0; i < 4; i++)
        chk_val("reg byte", reg_impl[3-i] ? reg_val[8*(3-i)+:8] : 8'h00, txq[i]);
      chk_val("reg ack first", a + (k < 3), first_ack);
      tick(2);
    end
    chk_val("order", 0, bad_c);
    print_verdict();
  end
endmodule
`default_nettype wire
